/* File: core/psir_regs.vh */
`ifndef PSIR_REGS_VH
`define PSIR_REGS_VH

// Direct management register numbers
`define PSIR_REG_MMD_CTRL      5'h0D
`define PSIR_REG_MMD_DATA      5'h0E
`define PSIR_REG_PHY_INT_STAT  5'h1A
`define PSIR_REG_GLOBAL_SRC    5'h1D

// MMD access control fields
`define PSIR_MMD_FUNC_HI       15
`define PSIR_MMD_FUNC_LO       14
`define PSIR_MMD_DEVAD_HI      4
`define PSIR_MMD_FUNC_ADDR     2'h0
`define PSIR_MMD_FUNC_DATA     2'h1
`define PSIR_MMD_FUNC_INC_RW   2'h2
`define PSIR_MMD_FUNC_INC_W    2'h3

// MMD device addresses
`define PSIR_DEV_PMA           5'h01
`define PSIR_DEV_PCS           5'h03
`define PSIR_DEV_XS            5'h04
`define PSIR_DEV_AN            5'h07

// MMD register addresses
`define PSIR_MMD_STATUS_ONE    16'h0001
`define PSIR_MMD_TS_CAP        16'h0708
`define PSIR_MMD_TX_MAX        16'h0709
`define PSIR_MMD_TX_MIN        16'h070B
`define PSIR_MMD_RX_MAX        16'h070D
`define PSIR_MMD_RX_MIN        16'h070F
`define PSIR_MMD_LP_CAP        16'h0014
`define PSIR_MMD_WAKE_CNT      16'h0016
`define PSIR_MMD_ADV_LOCAL     16'h003C
`define PSIR_MMD_ADV_PARTNER   16'h003D

// Field positions
`define PSIR_GSRC_TS_LO        8
`define PSIR_GSRC_PHY_LO       0
`define PSIR_ST_LINK_BIT       2
`define PSIR_ST_TX_LPI_LH      11
`define PSIR_ST_RX_LPI_LH      10
`define PSIR_ST_TX_LPI_NOW     9
`define PSIR_ST_RX_LPI_NOW     8
`define PSIR_ADV_MASK          16'h0006

// Reset values
`define PSIR_RST_SRC           4'hF
`define PSIR_RST_WORD          16'h0000

`endif

/* File: core/psir_status_regs.v */
`timescale 1ns/10ps
`include "psir_regs.vh"

// Behaviour
// - Global bits 11:8 show, active low, which PHY time-stamp unit interrupted.
// - Time-stamp source bit is 0 while that interrupt is asserted, 1 once cleared.
// - Global bits 3:0 show, active low, which PHY raised the shared interrupt.
// - A PHY source bit returns to 1 when that PHY reads register 26.
// - Extended registers are reached only through registers 13 and 14.
// - Time-sync capability and delay words read zero while link is down.
// - Device 1 delay words at 1801, 1803, 1805, 1807.
// - Device 3 time-stamp path delay words at 1801, 1803, 1805, 1807.
// - Device 4 MAC interface delay words at 1801, 1803, 1805, 1807.
// - Time-sync capability word at 1800 of devices 1, 3 and 4.
// - Decode 3.20, 3.22, 7.60 and 7.61.
// - PMA status 1 bit 2 is latching-low receive link status.
// - Pcs_status_one bit 11 latches high on transmit low-power idle.
// - Pcs_status_one bit 10 latches high on receive low-power idle.
// - Pcs_status_one bit 9 shows live transmit low-power idle.
// - Pcs_status_one bit 8 shows live receive low-power idle.
// - PCS status flags follow the currently active media path.
// - 16-bit wake fault counter counts faults, clears on read and reset.
// - Partner advertisement ignores writes, loads partner ability after negotiation.
module psir_status_regs #(
    parameter [15:0] PMA_TS_CAP  = 16'h0003,
    parameter [15:0] PMA_TX_MAX  = 16'h0000,
    parameter [15:0] PMA_TX_MIN  = 16'h0000,
    parameter [15:0] PMA_RX_MAX  = 16'h0000,
    parameter [15:0] PMA_RX_MIN  = 16'h0000,
    parameter [15:0] PCS_TS_CAP  = 16'h0003,
    parameter [15:0] PCS_TX_MAX  = 16'h0000,
    parameter [15:0] PCS_TX_MIN  = 16'h0000,
    parameter [15:0] PCS_RX_MAX  = 16'h0000,
    parameter [15:0] PCS_RX_MIN  = 16'h0000,
    parameter [15:0] XS_TS_CAP   = 16'h0003,
    parameter [15:0] XS_TX_MAX   = 16'h0000,
    parameter [15:0] XS_TX_MIN   = 16'h0000,
    parameter [15:0] XS_RX_MAX   = 16'h0000,
    parameter [15:0] XS_RX_MIN   = 16'h0000,
    parameter [15:0] LP_CAP      = 16'h0006
) (
    input  wire        clk_in,
    input  wire        nrst_in,
    input  wire        ce_in,
    input  wire        soft_rst_in,
    input  wire        mgmt_rd_in,
    input  wire        mgmt_wr_in,
    input  wire [1:0]  mgmt_port_in,
    input  wire [4:0]  mgmt_addr_in,
    input  wire [15:0] mgmt_wdata_in,
    input  wire [3:0]  phy_int_in,
    input  wire [3:0]  ts_int_in,
    input  wire        pma_link_in,
    input  wire        media_sel_in,
    input  wire [1:0]  pcs_link_in,
    input  wire [1:0]  tx_lpi_in,
    input  wire [1:0]  rx_lpi_in,
    input  wire        wake_fault_in,
    input  wire        an_done_in,
    input  wire [15:0] partner_adv_in,
    output reg  [15:0] mgmt_rdata_out,
    output reg         mgmt_rvalid_out
);

    // ****************************************
    // State
    // ****************************************
    reg  [3:0]  phy_src_q;
    reg  [3:0]  phy_int_prev_q;
    reg  [3:0]  ts_src_q;
    reg  [15:0] mmd_ctrl_q;
    reg  [15:0] mmd_addr_q;
    reg         pma_link_q;
    reg         pcs_link_q;
    reg         tx_lpi_lh_q;
    reg         rx_lpi_lh_q;
    reg  [15:0] wake_cnt_q;
    reg  [15:0] adv_local_q;
    reg  [15:0] adv_partner_q;

    // ****************************************
    // Active media selection
    // ****************************************
    wire        pcs_link_now = pcs_link_in[media_sel_in];
    wire        tx_lpi_now   = tx_lpi_in[media_sel_in];
    wire        rx_lpi_now   = rx_lpi_in[media_sel_in];

    // ****************************************
    // Access decode
    // ****************************************
    wire [1:0]  mmd_func   = mmd_ctrl_q[`PSIR_MMD_FUNC_HI:`PSIR_MMD_FUNC_LO];
    wire [4:0]  mmd_dev    = mmd_ctrl_q[`PSIR_MMD_DEVAD_HI:0];
    wire        data_sel   = (mgmt_addr_in == `PSIR_REG_MMD_DATA) && (mmd_func != `PSIR_MMD_FUNC_ADDR);
    wire        data_rd    = mgmt_rd_in && data_sel;
    wire        data_wr    = mgmt_wr_in && data_sel;
    wire        inc_addr   = (data_rd && (mmd_func == `PSIR_MMD_FUNC_INC_RW)) ||
                             (data_wr && (mmd_func[1] == 1'b1));

    function hit;
        input [4:0]  dev;
        input [15:0] addr;
        begin
            hit = (mmd_dev == dev) && (mmd_addr_q == addr);
        end
    endfunction

    // Delay and capability words, zero without link
    function [15:0] ts_word;
        input [15:0] w;
        begin
            ts_word = pma_link_in ? w : `PSIR_RST_WORD;
        end
    endfunction

    wire        rd_pma_st  = data_rd && hit(`PSIR_DEV_PMA, `PSIR_MMD_STATUS_ONE);
    wire        rd_pcs_st  = data_rd && hit(`PSIR_DEV_PCS, `PSIR_MMD_STATUS_ONE);
    wire        rd_wake    = data_rd && hit(`PSIR_DEV_PCS, `PSIR_MMD_WAKE_CNT);
    wire        rd_phy_int = mgmt_rd_in && (mgmt_addr_in == `PSIR_REG_PHY_INT_STAT);

    // ****************************************
    // Extended register read mux
    // ****************************************
    reg  [15:0] mmd_rdata;
    always @* begin
        mmd_rdata = `PSIR_RST_WORD;
        case (mmd_dev)
            `PSIR_DEV_PMA: begin
                case (mmd_addr_q)
                    `PSIR_MMD_STATUS_ONE: mmd_rdata[`PSIR_ST_LINK_BIT] = pma_link_q;
                    `PSIR_MMD_TS_CAP:     mmd_rdata = ts_word(PMA_TS_CAP);
                    `PSIR_MMD_TX_MAX:     mmd_rdata = ts_word(PMA_TX_MAX);
                    `PSIR_MMD_TX_MIN:     mmd_rdata = ts_word(PMA_TX_MIN);
                    `PSIR_MMD_RX_MAX:     mmd_rdata = ts_word(PMA_RX_MAX);
                    `PSIR_MMD_RX_MIN:     mmd_rdata = ts_word(PMA_RX_MIN);
                    default:              mmd_rdata = `PSIR_RST_WORD;
                endcase
            end
            `PSIR_DEV_PCS: begin
                case (mmd_addr_q)
                    `PSIR_MMD_STATUS_ONE: begin
                        mmd_rdata[`PSIR_ST_TX_LPI_LH]  = tx_lpi_lh_q;
                        mmd_rdata[`PSIR_ST_RX_LPI_LH]  = rx_lpi_lh_q;
                        mmd_rdata[`PSIR_ST_TX_LPI_NOW] = tx_lpi_now;
                        mmd_rdata[`PSIR_ST_RX_LPI_NOW] = rx_lpi_now;
                        mmd_rdata[`PSIR_ST_LINK_BIT]   = pcs_link_q;
                    end
                    `PSIR_MMD_TS_CAP:     mmd_rdata = ts_word(PCS_TS_CAP);
                    `PSIR_MMD_TX_MAX:     mmd_rdata = ts_word(PCS_TX_MAX);
                    `PSIR_MMD_TX_MIN:     mmd_rdata = ts_word(PCS_TX_MIN);
                    `PSIR_MMD_RX_MAX:     mmd_rdata = ts_word(PCS_RX_MAX);
                    `PSIR_MMD_RX_MIN:     mmd_rdata = ts_word(PCS_RX_MIN);
                    `PSIR_MMD_LP_CAP:     mmd_rdata = LP_CAP & `PSIR_ADV_MASK;
                    `PSIR_MMD_WAKE_CNT:   mmd_rdata = wake_cnt_q;
                    default:              mmd_rdata = `PSIR_RST_WORD;
                endcase
            end
            `PSIR_DEV_XS: begin
                case (mmd_addr_q)
                    `PSIR_MMD_TS_CAP:     mmd_rdata = ts_word(XS_TS_CAP);
                    `PSIR_MMD_TX_MAX:     mmd_rdata = ts_word(XS_TX_MAX);
                    `PSIR_MMD_TX_MIN:     mmd_rdata = ts_word(XS_TX_MIN);
                    `PSIR_MMD_RX_MAX:     mmd_rdata = ts_word(XS_RX_MAX);
                    `PSIR_MMD_RX_MIN:     mmd_rdata = ts_word(XS_RX_MIN);
                    default:              mmd_rdata = `PSIR_RST_WORD;
                endcase
            end
            `PSIR_DEV_AN: begin
                case (mmd_addr_q)
                    `PSIR_MMD_ADV_LOCAL:   mmd_rdata = adv_local_q;
                    `PSIR_MMD_ADV_PARTNER: mmd_rdata = adv_partner_q;
                    default:               mmd_rdata = `PSIR_RST_WORD;
                endcase
            end
            default: mmd_rdata = `PSIR_RST_WORD;
        endcase
    end

    // ****************************************
    // Direct register read mux
    // ****************************************
    reg  [15:0] rdata_d;
    always @* begin
        rdata_d = `PSIR_RST_WORD;
        case (mgmt_addr_in)
            `PSIR_REG_GLOBAL_SRC: begin
                rdata_d[`PSIR_GSRC_TS_LO+3:`PSIR_GSRC_TS_LO]   = ts_src_q;
                rdata_d[`PSIR_GSRC_PHY_LO+3:`PSIR_GSRC_PHY_LO] = phy_src_q;
            end
            `PSIR_REG_MMD_CTRL: rdata_d = mmd_ctrl_q;
            `PSIR_REG_MMD_DATA: rdata_d = data_sel ? mmd_rdata : mmd_addr_q;
            default:            rdata_d = `PSIR_RST_WORD;
        endcase
    end

    // ****************************************
    // Per-PHY interrupt source indication
    // ****************************************
    reg  [3:0]  phy_src_d;
    integer     i;
    always @* begin
        phy_src_d = phy_src_q;
        for (i = 0; i < 4; i = i + 1) begin
            if (rd_phy_int && (mgmt_port_in == i[1:0])) begin
                phy_src_d[i] = 1'b1;
            end
            if (phy_int_in[i] && !phy_int_prev_q[i]) begin
                phy_src_d[i] = 1'b0;
            end
        end
    end

    // ****************************************
    // Interrupt source registers
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phy_src_q      <= `PSIR_RST_SRC;
            phy_int_prev_q <= 4'h0;
            ts_src_q       <= `PSIR_RST_SRC;
        end else if (ce_in) begin
            // Software reset sets the per-PHY source bits back to 1
            if (soft_rst_in) begin
                phy_src_q <= `PSIR_RST_SRC;
            end else begin
                phy_src_q <= phy_src_d;
            end
            // Edge history for the per-PHY bits
            phy_int_prev_q <= phy_int_in;
            // Stamp bits follow the interrupt lines
            ts_src_q       <= ~ts_int_in;
        end
    end

    // ****************************************
    // Indirect access control
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mmd_ctrl_q <= `PSIR_RST_WORD;
            mmd_addr_q <= `PSIR_RST_WORD;
        end else if (ce_in) begin
            if (soft_rst_in) begin
                mmd_ctrl_q <= `PSIR_RST_WORD;
                mmd_addr_q <= `PSIR_RST_WORD;
            end else begin
                // Function and device select
                if (mgmt_wr_in && (mgmt_addr_in == `PSIR_REG_MMD_CTRL)) begin
                    mmd_ctrl_q <= mgmt_wdata_in;
                end
                // Address load, or post-increment after a data read in function 2 or a data write in function 2 or 3
                if (mgmt_wr_in && (mgmt_addr_in == `PSIR_REG_MMD_DATA) && !data_sel) begin
                    mmd_addr_q <= mgmt_wdata_in;
                end else if (inc_addr) begin
                    mmd_addr_q <= mmd_addr_q + 16'h0001;
                end
            end
        end
    end

    // ****************************************
    // Link status latches
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pma_link_q <= 1'b0;
            pcs_link_q <= 1'b0;
        end else if (ce_in) begin
            if (soft_rst_in) begin
                pma_link_q <= 1'b0;
                pcs_link_q <= 1'b0;
            end else begin
                // Latching low: reload live on read, loss always wins
                if (rd_pma_st) begin
                    pma_link_q <= pma_link_in;
                end else if (!pma_link_in) begin
                    pma_link_q <= 1'b0;
                end
                // Same rule for the active media path
                if (rd_pcs_st) begin
                    pcs_link_q <= pcs_link_now;
                end else if (!pcs_link_now) begin
                    pcs_link_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Low-power idle latches
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            tx_lpi_lh_q <= 1'b0;
            rx_lpi_lh_q <= 1'b0;
        end else if (ce_in) begin
            // Read reloads live values
            if (soft_rst_in) begin
                tx_lpi_lh_q <= 1'b0;
                rx_lpi_lh_q <= 1'b0;
            end else if (rd_pcs_st) begin
                tx_lpi_lh_q <= tx_lpi_now;
                rx_lpi_lh_q <= rx_lpi_now;
            end else begin
                // Latching high: any idle seen sets the flag
                if (tx_lpi_now) begin
                    tx_lpi_lh_q <= 1'b1;
                end
                if (rx_lpi_now) begin
                    rx_lpi_lh_q <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // Wake fault counter
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_cnt_q <= `PSIR_RST_WORD;
        end else if (ce_in) begin
            // Event in the read cycle is kept
            // Saturates at all ones
            if (soft_rst_in) begin
                wake_cnt_q <= `PSIR_RST_WORD;
            end else if (rd_wake) begin
                wake_cnt_q <= wake_fault_in ? 16'h0001 : `PSIR_RST_WORD;
            end else if (wake_fault_in && (wake_cnt_q != 16'hFFFF)) begin
                wake_cnt_q <= wake_cnt_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Advertisement words
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            adv_local_q   <= `PSIR_RST_WORD;
            adv_partner_q <= `PSIR_RST_WORD;
        end else if (ce_in) begin
            if (soft_rst_in) begin
                adv_local_q   <= `PSIR_RST_WORD;
                adv_partner_q <= `PSIR_RST_WORD;
            end else begin
                // Local word keeps only the advertised bits
                if (data_wr && hit(`PSIR_DEV_AN, `PSIR_MMD_ADV_LOCAL)) begin
                    adv_local_q <= mgmt_wdata_in & `PSIR_ADV_MASK;
                end
                // Partner word follows while negotiation is done
                if (an_done_in) begin
                    adv_partner_q <= partner_adv_in & `PSIR_ADV_MASK;
                end
            end
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mgmt_rdata_out  <= `PSIR_RST_WORD;
            mgmt_rvalid_out <= 1'b0;
        end else if (ce_in) begin
            // Valid is a one-cycle answer to each read
            mgmt_rvalid_out <= mgmt_rd_in;
            // Data holds until the next read
            if (mgmt_rd_in) begin
                mgmt_rdata_out <= rdata_d;
            end
        end
    end

endmodule

/* File: tb/psir_mgmt_model.sv */
`timescale 1ns/10ps
// ********
// Management controller model
// ********
module psir_mgmt_model (
    input  wire        clk_in,
    input  wire        rvalid_in,
    input  wire [15:0] rdata_in,
    output reg         rd_out,
    output reg         wr_out,
    output reg  [1:0]  port_out,
    output reg  [4:0]  addr_out,
    output reg  [15:0] wdata_out
);
    integer n;
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        port_out = 2'h0;
        addr_out = 5'h00;
        wdata_out = 16'h5A5A;
    end
    task wr_reg(input [4:0] a, input [15:0] d);
        begin
            @(posedge clk_in);
            wr_out <= 1'b1;
            addr_out <= a;
            wdata_out <= d;
            @(posedge clk_in);
            wr_out <= 1'b0;
            wdata_out <= ~d;
        end
    endtask
    task rd_reg(input [4:0] a, input [1:0] p, output [15:0] d);
        begin
            @(posedge clk_in);
            rd_out <= 1'b1;
            addr_out <= a;
            port_out <= p;
            @(posedge clk_in);
            rd_out <= 1'b0;
            n = 0;
            @(posedge clk_in);
            while (rvalid_in !== 1'b1 && n < 4) begin
                @(posedge clk_in);
                n = n + 1;
            end
            d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
        end
    endtask
    // Extended words only via control then data
    task mmd_sel(input [4:0] dev, input [15:0] ra);
        begin
            wr_reg(5'h0D, {11'h000, dev});
            wr_reg(5'h0E, ra);
            wr_reg(5'h0D, {11'h200, dev});
        end
    endtask
endmodule

/* File: tb/psir_status_regs_asserts.sv */
`timescale 1ns/10ps
// ********
// Port checker
// ********
module psir_status_regs_asserts (
    input wire        clk_in,
    input wire        nrst_in,
    input wire        ce_in,
    input wire        mgmt_rd_in,
    input wire [4:0]  mgmt_addr_in,
    input wire [3:0]  phy_int_in,
    input wire [3:0]  ts_int_in,
    input wire [15:0] mgmt_rdata_out,
    input wire        mgmt_rvalid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    wire rd_ok    = ce_in && mgmt_rd_in;
    wire rd_gsrc  = rd_ok && (mgmt_addr_in == 5'h1D);
    wire rd_unmap = rd_ok && !(mgmt_addr_in inside {5'h0D, 5'h0E, 5'h1A, 5'h1D});
    a_rvalid_pulse: assert property (rd_ok |=> mgmt_rvalid_out)
        else $error("read not answered");
    a_rvalid_idle: assert property (ce_in && !mgmt_rd_in |=> !mgmt_rvalid_out)
        else $error("read valid without read");
    a_rdata_hold: assert property (ce_in && !mgmt_rd_in |=> $stable(mgmt_rdata_out))
        else $error("read data moved");
    a_freeze_out: assert property (!ce_in |=> $stable(mgmt_rdata_out) && $stable(mgmt_rvalid_out))
        else $error("outputs moved while disabled");
    a_src_reserved: assert property (rd_gsrc |=> mgmt_rdata_out[15:12] == 4'h0 && mgmt_rdata_out[7:4] == 4'h0)
        else $error("reserved source bits set");
    a_ts_source: assert property (rd_gsrc && $stable(ts_int_in) && $past(ce_in) && $past(nrst_in)
        |=> mgmt_rdata_out[11:8] == ~$past(ts_int_in))
        else $error("stamp source bits wrong");
    a_phy_source: assert property (rd_gsrc && $past(ce_in)
        |=> (mgmt_rdata_out[3:0] & $past(phy_int_in, 2) & ~$past(phy_int_in, 3)) == 4'h0)
        else $error("new source not reported");
    a_unmap_zero: assert property (rd_unmap |=> mgmt_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
endmodule
bind psir_status_regs psir_status_regs_asserts psir_status_regs_asserts_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .mgmt_rd_in(mgmt_rd_in), .mgmt_addr_in(mgmt_addr_in),
    .phy_int_in(phy_int_in), .ts_int_in(ts_int_in), .mgmt_rdata_out(mgmt_rdata_out),
    .mgmt_rvalid_out(mgmt_rvalid_out));

/* File: tb/psir_status_regs_test.sv */
`timescale 1ns/10ps
// ********
// Register bank testbench
// ********
module psir_status_regs_test;
    reg         clk_in = 1'b0;
    reg         nrst_in = 1'b0;
    reg         ce_in = 1'b1;
    reg         media_sel_in = 1'b1;
    reg         soft_rst_in = 1'b0;
    reg  [3:0]  phy_int_in = 4'h0;
    reg  [3:0]  ts_int_in = 4'h0;
    reg         pma_link_in = 1'b1;
    reg  [1:0]  pcs_link_in = 2'h2;
    reg  [1:0]  tx_lpi_in = 2'h0;
    reg  [1:0]  rx_lpi_in = 2'h0;
    reg         wake_fault_in = 1'b0;
    reg         an_done_in = 1'b0;
    reg  [15:0] partner_adv_in = 16'h0000;
    reg  [15:0] got;
    reg  [15:0] ev;
    reg  [4:0]  dv;
    wire        rd;
    wire        wr;
    wire        rvalid;
    wire [1:0]  port;
    wire [4:0]  addr;
    wire [15:0] wdata;
    wire [15:0] rdata;
    integer     fail_count = 0;
    integer     tests_run = 0;
    integer     cycles = 0;
    integer     j;
    integer     k;
    integer     l;
    always #2 clk_in = ~clk_in;
    psir_mgmt_model psir_mgmt_model_inst (.clk_in(clk_in), .rvalid_in(rvalid), .rdata_in(rdata), .rd_out(rd),
        .wr_out(wr), .port_out(port), .addr_out(addr), .wdata_out(wdata));
    psir_status_regs #(.PMA_TX_MAX(16'h1101), .PMA_RX_MIN(16'h1107), .PCS_TS_CAP(16'h0002),
        .PCS_TX_MIN(16'h3103), .XS_RX_MAX(16'h4105)
    ) psir_status_regs_inst (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .soft_rst_in(soft_rst_in),
        .mgmt_rd_in(rd), .mgmt_wr_in(wr), .mgmt_port_in(port), .mgmt_addr_in(addr), .mgmt_wdata_in(wdata),
        .phy_int_in(phy_int_in), .ts_int_in(ts_int_in), .pma_link_in(pma_link_in), .media_sel_in(media_sel_in),
        .pcs_link_in(pcs_link_in), .tx_lpi_in(tx_lpi_in), .rx_lpi_in(rx_lpi_in), .wake_fault_in(wake_fault_in),
        .an_done_in(an_done_in), .partner_adv_in(partner_adv_in), .mgmt_rdata_out(rdata),
        .mgmt_rvalid_out(rvalid));
    task tick(input integer c);
        repeat (c) @(posedge clk_in);
    endtask
    task chk(input [15:0] e);
        begin
            tests_run = tests_run + 1;
            if (got !== e) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED at %0t: read %h expected %h", $time, got, e);
            end
        end
    endtask
    task rdc(input [4:0] a, input [1:0] p, input [15:0] e);
        begin
            psir_mgmt_model_inst.rd_reg(a, p, got);
            chk(e);
        end
    endtask
    task mmd(input [4:0] d, input [15:0] ra, input [15:0] e);
        begin
            psir_mgmt_model_inst.mmd_sel(d, ra);
            rdc(5'h0E, 2'h0, e);
        end
    endtask
    task mmdw(input [4:0] d, input [15:0] ra, input [15:0] v);
        begin
            psir_mgmt_model_inst.mmd_sel(d, ra);
            psir_mgmt_model_inst.wr_reg(5'h0E, v);
        end
    endtask
    task wake(input integer c);
        repeat (c) begin
            wake_fault_in <= 1'b1;
            tick(1);
            wake_fault_in <= 1'b0;
            tick(1);
        end
    endtask
    task final_report;
        begin
            $display("Checks %0d, mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    always @(posedge clk_in) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    initial begin
        tick(20);
        nrst_in <= 1'b1;
        tick(2);
        rdc(5'h1D, 2'h0, 16'h0F0F);
        ts_int_in <= 4'h5;
        tick(2);
        rdc(5'h1D, 2'h0, 16'h0A0F);
        ts_int_in <= 4'h0;
        tick(2);
        rdc(5'h1D, 2'h0, 16'h0F0F);
        phy_int_in <= 4'h6;
        rdc(5'h1D, 2'h0, 16'h0F09);
        psir_mgmt_model_inst.rd_reg(5'h1A, 2'h1, got);
        rdc(5'h1D, 2'h0, 16'h0F0B);
        psir_mgmt_model_inst.rd_reg(5'h1A, 2'h2, got);
        rdc(5'h1D, 2'h0, 16'h0F0F);
        $display("Source bit test done");
        for (l = 0; l < 2; l = l + 1) begin
            pma_link_in <= (l == 0);
            for (k = 0; k < 15; k = k + 1) begin
                dv = (k < 5) ? 5'h01 : (k < 10) ? 5'h03 : 5'h04;
                j = k % 5;
                ev = (j == 0) ? ((k == 5) ? 16'h0002 : 16'h0003) : (k == 1 || k == 4 || k == 7 || k == 13) ?
                    {dv[3:0], 8'h10, 4'(2 * j - 1)} : 16'h0000;
                mmd(dv, 16'h0708 + ((j == 0) ? 16'h0000 : 16'(2 * j - 1)), (l == 1) ? 16'h0000 : ev);
            end
        end
        mmd(5'h03, 16'h0014, 16'h0006);
        $display("Time-sync word test done");
        pma_link_in <= 1'b1;
        mmd(5'h01, 16'h0001, 16'h0000);
        mmd(5'h01, 16'h0001, 16'h0004);
        psir_mgmt_model_inst.rd_reg(5'h0E, 2'h0, got);
        tx_lpi_in <= 2'h2;
        rx_lpi_in <= 2'h2;
        mmd(5'h03, 16'h0001, 16'h0F00);
        tx_lpi_in <= 2'h1;
        rx_lpi_in <= 2'h1;
        pcs_link_in <= 2'h1;
        tick(1);
        pcs_link_in <= 2'h3;
        mmd(5'h03, 16'h0001, 16'h0C00);
        mmd(5'h03, 16'h0001, 16'h0004);
        media_sel_in <= 1'b0;
        mmd(5'h03, 16'h0001, 16'h0F04);
        $display("Status latch test done");
        wake(3);
        mmd(5'h03, 16'h0016, 16'h0003);
        mmd(5'h03, 16'h0016, 16'h0000);
        ce_in <= 1'b0;
        wake(2);
        ce_in <= 1'b1;
        mmd(5'h03, 16'h0016, 16'h0000);
        wake(2);
        soft_rst_in <= 1'b1;
        tick(1);
        soft_rst_in <= 1'b0;
        mmd(5'h03, 16'h0016, 16'h0000);
        $display("Wake counter test done");
        mmdw(5'h07, 16'h003C, 16'hFFFF);
        mmd(5'h07, 16'h003C, 16'h0006);
        partner_adv_in <= 16'hFFFF;
        mmdw(5'h07, 16'h003D, 16'hFFFF);
        mmd(5'h07, 16'h003D, 16'h0000);
        an_done_in <= 1'b1;
        tick(1);
        an_done_in <= 1'b0;
        partner_adv_in <= 16'h0000;
        mmd(5'h07, 16'h003D, 16'h0006);
        psir_mgmt_model_inst.wr_reg(5'h1D, 16'h0000);
        rdc(5'h05, 2'h0, 16'h0000);
        rdc(5'h1D, 2'h0, 16'h0F0F);
        $display("Advertisement test done");
        final_report;
    end
endmodule
